/* File: design/ed_power_pkg.sv */
package ed_power_pkg;
    // Register location on the management bus
    localparam logic [4:0] ENERGY_CONTROL_REGISTER_ADDR = 5'h1d;
    // Field positions
    localparam int ENERGY_MODE_ENABLE_BIT = 15;
    localparam int AUTO_WAKE_ENABLE_BIT = 14;
    localparam int AUTO_SLEEP_ENABLE_BIT = 13;
    localparam int MANUAL_POWER_TOGGLE_BIT = 12;
    localparam int PULSE_BURST_DISABLE_BIT = 11;
    localparam int SENSE_POWER_STATE_BIT = 10;
    localparam int ERROR_THRESHOLD_REACHED_BIT = 9;
    localparam int DATA_THRESHOLD_REACHED_BIT = 8;
    localparam int ERROR_THRESHOLD_LSB = 4;
    localparam int DATA_THRESHOLD_LSB = 0;
    // Reset values
    localparam logic [3:0] THRESHOLD_RESET = 4'h1;
    localparam logic AUTO_WAKE_RESET = 1'b1;
    localparam logic AUTO_SLEEP_RESET = 1'b1;
    // Pulse burst lengths
    localparam logic [2:0] BURST_PULSES = 3'h4;
    localparam logic [2:0] SINGLE_PULSES = 3'h1;
    // Quiet-line timing
    localparam longint CLOCK_HZ = 20000000;
    localparam longint QUIET_TIME_S = 2;
    localparam longint QUIET_CYCLES = QUIET_TIME_S * CLOCK_HZ;
    // Management access to the register
    typedef struct packed {
        logic write;
        logic read;
        logic [4:0] addr;
        logic [15:0] data;
    } mgmt_req_s;
endpackage

/* File: design/event_counter.sv */
`timescale 1ns/1ps
`default_nettype none
// Saturating event counter with threshold compare
module event_counter
    import ed_power_pkg::*;
#(
    parameter int WIDTH = 4
)(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic clear,
    input wire logic event_in,
    input wire logic [WIDTH-1:0] threshold,
    output logic reached
);
    logic [WIDTH-1:0] count_q;
    logic [WIDTH-1:0] count_d;
    wire atMax = &count_q;

    // Saturate so a long burst never wraps below the threshold
    assign count_d = clear ? '0 : ((event_in && !atMax) ? count_q + 1'b1 : count_q);
    // Compare the updated count so the event that reaches the threshold is the one that raises the flag
    assign reached = (count_d >= threshold);

    always_ff @(posedge core_clk)
    begin
        if (rst)
            count_q <= '0;
        else
            count_q <= count_d;
    end
endmodule
`default_nettype wire

/* File: design/line_energy_detect_power.sv */
// Contract
// - Energy-detect power mode runs only while enable bit 15 is set; resets clear.
// - Auto wake bit 14, reset 1, powers up when data threshold reached.
// - Auto sleep bit 13, reset 1, powers down when no line energy.
// - Self-clearing bit 12 toggles power state immediately, ignoring thresholds and timers.
// - A power-up while no burst runs sends 4 detect pulses, or one when bit 11 set.
// - Bit 10 reads 1 powered up, 0 powered down.
// - Bit 9 sets at error threshold, clears on read, no action taken.
// - Bit 8 sets when data events reach threshold, clears on read.
// - Bits 7:4 hold error threshold, reset 0001.
// - Bits 3:0 hold data threshold, reset 0001.
// - Counters clear after 2 seconds with no data event.
`timescale 1ns/1ps
`default_nettype none
module line_energy_detect_power
    import ed_power_pkg::*;
#(
    parameter longint QUIET_LIMIT = QUIET_CYCLES,
    parameter int PULSE_GAP = 16
)(
    input wire logic core_clk,
    input wire logic rst,
    input wire mgmt_req_s mgmtReq,
    output logic [15:0] readData,
    input wire logic dataEventPin,
    input wire logic errorEventPin,
    input wire logic lineEnergyPin,
    output logic sensePowerUp,
    output logic detectPulse,
    output logic autoCrossoverAdvice
);
    typedef enum logic [1:0] {
        PULSE_IDLE = 2'b00,
        PULSE_HIGH = 2'b01,
        PULSE_GAPW = 2'b10
    } pulse_e;

    // Three-stage synchronisers for line-side inputs
    logic [2:0] dataSync_q;
    logic [2:0] errSync_q;
    logic [2:0] energySync_q;
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            dataSync_q <= 3'h0;
            errSync_q <= 3'h0;
            energySync_q <= 3'h0;
        end
        else
        begin
            dataSync_q <= {dataSync_q[1:0], dataEventPin};
            errSync_q <= {errSync_q[1:0], errorEventPin};
            energySync_q <= {energySync_q[1:0], lineEnergyPin};
        end
    end

    // Stages two and three agree on a rising edge to count an event
    logic dataLevel_q;
    logic errLevel_q;
    logic energyLevel_q;
    wire dataAgree = (dataSync_q[1] == dataSync_q[2]);
    wire errAgree = (errSync_q[1] == errSync_q[2]);
    wire energyAgree = (energySync_q[1] == energySync_q[2]);
    wire dataLevel_d = dataAgree ? dataSync_q[2] : dataLevel_q;
    wire errLevel_d = errAgree ? errSync_q[2] : errLevel_q;
    wire energyLevel_d = energyAgree ? energySync_q[2] : energyLevel_q;
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            dataLevel_q <= 1'b0;
            errLevel_q <= 1'b0;
            energyLevel_q <= 1'b0;
        end
        else
        begin
            dataLevel_q <= dataLevel_d;
            errLevel_q <= errLevel_d;
            energyLevel_q <= energyLevel_d;
        end
    end

    // Register fields
    logic modeEnable_q;
    logic autoWake_q;
    logic autoSleep_q;
    logic burstDisable_q;
    logic powerUp_q;
    logic errReached_q;
    logic dataReached_q;
    logic [3:0] errThreshold_q;
    logic [3:0] dataThreshold_q;

    // Events only count while the mode is enabled
    wire dataEvent = modeEnable_q && dataLevel_d && !dataLevel_q;
    wire errEvent = modeEnable_q && errLevel_d && !errLevel_q;

    // Address decode
    wire regHit = (mgmtReq.addr == ENERGY_CONTROL_REGISTER_ADDR);
    wire regWrite = mgmtReq.write && regHit;
    wire regRead = mgmtReq.read && regHit;
    wire manualToggle = regWrite && mgmtReq.data[MANUAL_POWER_TOGGLE_BIT];

    // Quiet timer: long silence on data events flushes the counters
    logic [31:0] quietCount_q;
    wire quietExpired = (quietCount_q >= 32'(QUIET_LIMIT - 1));
    wire counterClear = !modeEnable_q || (quietExpired && !dataEvent);
    always_ff @(posedge core_clk)
    begin
        if (rst || dataEvent || quietExpired)
            quietCount_q <= 32'h0;
        else
            quietCount_q <= quietCount_q + 32'h1;
    end

    logic errMet;
    logic dataMet;
    event_counter #(.WIDTH(4)) errCounter (
        .core_clk(core_clk),
        .rst(rst),
        .clear(counterClear),
        .event_in(errEvent),
        .threshold(errThreshold_q),
        .reached(errMet)
    );
    event_counter #(.WIDTH(4)) dataCounter (
        .core_clk(core_clk),
        .rst(rst),
        .clear(counterClear),
        .event_in(dataEvent),
        .threshold(dataThreshold_q),
        .reached(dataMet)
    );

    // Power state decisions; manual toggle overrides thresholds and timers
    wire wakeReq = autoWake_q && dataMet && !powerUp_q;
    wire sleepReq = autoSleep_q && !energyLevel_q && powerUp_q;
    wire powerUp_d = !modeEnable_q ? 1'b0 :
                     manualToggle ? !powerUp_q :
                     wakeReq ? 1'b1 :
                     sleepReq ? 1'b0 : powerUp_q;
    wire powerRise = powerUp_d && !powerUp_q;

    // Control fields; bit 12 self-clears so it is never stored
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            modeEnable_q <= 1'b0;
            autoWake_q <= AUTO_WAKE_RESET;
            autoSleep_q <= AUTO_SLEEP_RESET;
            burstDisable_q <= 1'b0;
            errThreshold_q <= THRESHOLD_RESET;
            dataThreshold_q <= THRESHOLD_RESET;
            powerUp_q <= 1'b0;
        end
        else
        begin
            if (regWrite)
            begin
                modeEnable_q <= mgmtReq.data[ENERGY_MODE_ENABLE_BIT];
                autoWake_q <= mgmtReq.data[AUTO_WAKE_ENABLE_BIT];
                autoSleep_q <= mgmtReq.data[AUTO_SLEEP_ENABLE_BIT];
                burstDisable_q <= mgmtReq.data[PULSE_BURST_DISABLE_BIT];
                errThreshold_q <= mgmtReq.data[ERROR_THRESHOLD_LSB +: 4];
                dataThreshold_q <= mgmtReq.data[DATA_THRESHOLD_LSB +: 4];
            end
            powerUp_q <= powerUp_d;
        end
    end

    // Sticky flags: a new crossing in the read cycle wins over the clear
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            errReached_q <= 1'b0;
            dataReached_q <= 1'b0;
        end
        else
        begin
            errReached_q <= (errMet && errEvent) || (errReached_q && !regRead);
            dataReached_q <= (dataMet && dataEvent) || (dataReached_q && !regRead);
        end
    end

    // Read data is registered the cycle after the read strobe
    logic [15:0] readWord;
    assign readWord = {modeEnable_q, autoWake_q, autoSleep_q, 1'b0, burstDisable_q,
                       powerUp_q, errReached_q, dataReached_q,
                       errThreshold_q, dataThreshold_q};
    always_ff @(posedge core_clk)
    begin
        if (rst)
            readData <= 16'h0000;
        else if (mgmtReq.read)
            readData <= regHit ? readWord : 16'h0000;
    end

    // Pulse burst generator, started at a power-up seen in PULSE_IDLE
    pulse_e pulseState_q;
    logic [2:0] pulsesLeft_q;
    logic [7:0] gapCount_q;
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            pulseState_q <= PULSE_IDLE;
            pulsesLeft_q <= 3'h0;
            gapCount_q <= 8'h00;
            detectPulse <= 1'b0;
        end
        else
        begin
            case (pulseState_q)
                PULSE_IDLE:
                begin
                    detectPulse <= 1'b0;
                    if (powerRise)
                    begin
                        pulsesLeft_q <= burstDisable_q ? SINGLE_PULSES : BURST_PULSES;
                        pulseState_q <= PULSE_HIGH;
                    end
                end
                PULSE_HIGH:
                begin
                    detectPulse <= 1'b1;
                    pulsesLeft_q <= pulsesLeft_q - 3'h1;
                    gapCount_q <= 8'(PULSE_GAP);
                    pulseState_q <= PULSE_GAPW;
                end
                PULSE_GAPW:
                begin
                    detectPulse <= 1'b0;
                    if (gapCount_q != 8'h00)
                        gapCount_q <= gapCount_q - 8'h01;
                    else if (pulsesLeft_q != 3'h0)
                        pulseState_q <= PULSE_HIGH;
                    else
                        pulseState_q <= PULSE_IDLE;
                end
                default:
                    pulseState_q <= PULSE_IDLE;
            endcase
        end
    end

    assign sensePowerUp = powerUp_q;
    // Advisory only: software owns the crossover setting
    assign autoCrossoverAdvice = modeEnable_q;
endmodule
`default_nettype wire

/* File: test/line_energy_detect_power_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module line_energy_detect_power_sva
    import ed_power_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire mgmt_req_s mgmtReq,
    input wire logic [15:0] readData,
    input wire logic dataEventPin,
    input wire logic errorEventPin,
    input wire logic lineEnergyPin,
    input wire logic sensePowerUp,
    input wire logic detectPulse,
    input wire logic autoCrossoverAdvice
);
    // Accesses that hit the control register; other addresses never count
    wire logic wr = mgmtReq.write && mgmtReq.addr == ENERGY_CONTROL_REGISTER_ADDR;
    wire logic rd = mgmtReq.read && mgmtReq.addr == ENERGY_CONTROL_REGISTER_ADDR;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    property p_adv; wr |=> autoCrossoverAdvice == $past(mgmtReq.data[15]); endproperty
    a_adv: assert property (p_adv) else $error("advice does not follow enable");
    property p_off; (!autoCrossoverAdvice) [*2] |-> !sensePowerUp; endproperty
    a_off: assert property (p_off) else $error("powered up while disabled");
    property p_man; wr && mgmtReq.data[15] && mgmtReq.data[12] && autoCrossoverAdvice && !sensePowerUp |-> ##[1:2] sensePowerUp; endproperty
    a_man: assert property (p_man) else $error("manual toggle ignored");
    property p_sc; rd |=> !readData[12]; endproperty
    a_sc: assert property (p_sc) else $error("toggle bit reads set");
    property p_pwr; rd |=> readData[10] == $past(sensePowerUp); endproperty
    a_pwr: assert property (p_pwr) else $error("power bit wrong");
    property p_rise; $rose(sensePowerUp) |-> ##[0:1] detectPulse; endproperty
    a_rise: assert property (p_rise) else $error("no pulse at power-up");
    property p_one; detectPulse |=> !detectPulse; endproperty
    a_one: assert property (p_one) else $error("pulse too long");
    property p_fld; wr ##1 !mgmtReq.write ##1 rd |=> readData[7:0] == $past(mgmtReq.data[7:0], 3); endproperty
    a_fld: assert property (p_fld) else $error("threshold fields lost");
endmodule
bind line_energy_detect_power line_energy_detect_power_sva i_sva (.core_clk(core_clk), .rst(rst), .mgmtReq(mgmtReq),
    .readData(readData), .dataEventPin(dataEventPin), .errorEventPin(errorEventPin), .lineEnergyPin(lineEnergyPin),
    .sensePowerUp(sensePowerUp), .detectPulse(detectPulse), .autoCrossoverAdvice(autoCrossoverAdvice));
`default_nettype wire

/* File: test/line_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module line_partner (
    input wire logic core_clk,
    input wire logic dataReq,
    input wire logic errReq,
    input wire logic energyReq,
    output logic dataEventPin,
    output logic errorEventPin,
    output logic lineEnergyPin
);
    logic [2:0] dataLen_q = 3'h0;
    logic [2:0] errLen_q = 3'h0;
    // Four-cycle pin pulses, long enough that no input synchroniser can miss one
    always_ff @(posedge core_clk)
    begin
        dataLen_q <= dataReq ? 3'h4 : dataLen_q - {2'h0, dataLen_q != 3'h0};
        errLen_q <= errReq ? 3'h4 : errLen_q - {2'h0, errLen_q != 3'h0};
        lineEnergyPin <= energyReq;
    end
    assign dataEventPin = dataLen_q != 3'h0;
    assign errorEventPin = errLen_q != 3'h0;
endmodule
`default_nettype wire

/* File: test/test_line_energy_detect_power.sv */
`timescale 1ns/1ps
`default_nettype none
module test_line_energy_detect_power
    import ed_power_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    mgmt_req_s mgmtReq = '0;
    logic dataReq = 1'b0, errReq = 1'b0, energyReq = 1'b0;
    logic [15:0] readData;
    logic dataEventPin, errorEventPin, lineEnergyPin, sensePowerUp, detectPulse, autoCrossoverAdvice;
    int errorCnt = 0, nChecks = 0, pulseCnt = 0, pulseBase = 0;
    localparam logic [4:0] A = ENERGY_CONTROL_REGISTER_ADDR;
    // Rows: address, written word, word read back (bits 12 and 10:8 never stick)
    logic [36:0] rows [4] = '{{A, 16'h00a5, 16'h00a5}, {A, 16'h67f3, 16'h60f3},
        {A, 16'h1b00, 16'h0800}, {5'h1c, 16'hffff, 16'h0000}};
    always #25 core_clk = ~core_clk;
    // Short quiet period keeps the run small
    line_energy_detect_power #(.QUIET_LIMIT(100), .PULSE_GAP(16)) i_dut (.core_clk(core_clk), .rst(rst),
        .mgmtReq(mgmtReq), .readData(readData), .dataEventPin(dataEventPin), .errorEventPin(errorEventPin),
        .lineEnergyPin(lineEnergyPin), .sensePowerUp(sensePowerUp), .detectPulse(detectPulse),
        .autoCrossoverAdvice(autoCrossoverAdvice));
    line_partner i_line (.core_clk(core_clk), .dataReq(dataReq), .errReq(errReq), .energyReq(energyReq),
        .dataEventPin(dataEventPin), .errorEventPin(errorEventPin), .lineEnergyPin(lineEnergyPin));
    // Burst counted in the background so it is judged as a whole
    always @(posedge core_clk)
    begin
        if (detectPulse === 1'b1)
        begin
            pulseCnt <= pulseCnt + 1;
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        nChecks++;
        if (seen !== exp)
        begin
            errorCnt++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One access; an idle edge follows so the strobe is never lowered and raised at once
    task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] d);
        mgmtReq = '{w, ~w, a, d};
        @(posedge core_clk);
        #2;
        mgmtReq = '0;
        @(posedge core_clk);
        #2;
    endtask
    task automatic ev(input logic d, input logic e);
        dataReq = d;
        errReq = e;
        @(posedge core_clk);
        #2;
        dataReq = 1'b0;
        errReq = 1'b0;
        repeat (12) @(posedge core_clk);
        #2;
    endtask
    task automatic waitPow(input logic p);
        for (int i = 0; i < 60 && sensePowerUp !== p; i++)
        begin
            @(posedge core_clk);
            #2;
        end
        chk({15'h0, sensePowerUp}, {15'h0, p}, "power");
    endtask
    task automatic giveVerdict();
        if (errorCnt == 0 && nChecks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        repeat (6) @(posedge core_clk);
        #2;
        rst = 1'b0;
        bus(1'b0, A, 16'h0);
        chk(readData, 16'h6011, "reset");
        foreach (rows[i])
        begin
            bus(1'b1, rows[i][36:32], rows[i][31:16]);
            bus(1'b0, rows[i][36:32], 16'h0);
            chk(readData, rows[i][15:0], "row");
        end
        bus(1'b1, A, 16'hc013);
        chk({15'h0, autoCrossoverAdvice}, 16'h1, "advice");
        ev(1'b1, 1'b0);
        ev(1'b1, 1'b0);
        bus(1'b0, A, 16'h0);
        chk(readData & 16'h0500, 16'h0, "below");
        // Pulses are judged against a snapshot so only the background counter writes pulseCnt
        pulseBase = pulseCnt;
        ev(1'b1, 1'b0);
        waitPow(1'b1);
        repeat (120) @(posedge core_clk);
        #2;
        chk(16'(pulseCnt - pulseBase), 16'h4, "burst");
        bus(1'b0, A, 16'h0);
        chk(readData & 16'h0700, 16'h0500, "dataflag");
        bus(1'b0, A, 16'h0);
        chk(readData & 16'h0700, 16'h0400, "dataclr");
        ev(1'b0, 1'b1);
        bus(1'b0, A, 16'h0);
        chk(readData & 16'h0700, 16'h0600, "errflag");
        bus(1'b0, A, 16'h0);
        chk(readData & 16'h0700, 16'h0400, "errclr");
        repeat (150) @(posedge core_clk);
        #2;
        ev(1'b1, 1'b0);
        ev(1'b1, 1'b0);
        repeat (150) @(posedge core_clk);
        #2;
        ev(1'b1, 1'b0);
        bus(1'b0, A, 16'h0);
        chk(readData & 16'h0100, 16'h0, "quiet");
        bus(1'b1, A, 16'h9013);
        waitPow(1'b0);
        energyReq = 1'b1;
        // Burst disable lands a write ahead, and line energy settles, before the manual power-up
        bus(1'b1, A, 16'ha813);
        repeat (8) @(posedge core_clk);
        #2;
        pulseBase = pulseCnt;
        bus(1'b1, A, 16'hb813);
        waitPow(1'b1);
        repeat (60) @(posedge core_clk);
        #2;
        chk(16'(pulseCnt - pulseBase), 16'h1, "single");
        energyReq = 1'b0;
        waitPow(1'b0);
        bus(1'b1, A, 16'h4013);
        chk({15'h0, autoCrossoverAdvice}, 16'h0, "off");
        ev(1'b1, 1'b0);
        ev(1'b1, 1'b0);
        ev(1'b1, 1'b0);
        waitPow(1'b0);
        giveVerdict();
    end
    initial
    begin
        repeat (6000) @(posedge core_clk);
        errorCnt++;
        giveVerdict();
    end
endmodule
`default_nettype wire
